// *** rtl/tsbi_map.svh ***
// Constants of the transmit segmented bus ingress: widths, depths, counts.
// Assumes inclusion by bare name from every file of the block.
`ifndef TSBI_MAP_SVH
`define TSBI_MAP_SVH

// ----------------------------------------
// Segment layout
// ----------------------------------------
`define TSBI_NSEG 4
`define TSBI_DATA_W 128
`define TSBI_CHAN_W 11
`define TSBI_MTY_W 4
`define TSBI_MTY_LOW_W 3
`define TSBI_MTY_LOW_ZERO 3'h0

// ----------------------------------------
// Buffering, burst control and statistics
// ----------------------------------------
`define TSBI_BUF_DEPTH 2
`define TSBI_CNT_W 2
`define TSBI_FILL_THRESH 2'h2
`define TSBI_BURST_CNT_W 5
`define TSBI_MAX_BURST_SEGS 5'h10
`define TSBI_STAT_W 16

`endif

// *** rtl/tsbi_pkg.sv ***
// Types of the transmit segmented bus ingress.
// Assumes tsbi_map.svh is on the include path.
`include "tsbi_map.svh"

package tsbi_pkg;

    // ----------------------------------------
    // One segment of the bus
    // ----------------------------------------
    typedef struct packed {
        logic [`TSBI_DATA_W-1:0] data;
        logic [`TSBI_CHAN_W-1:0] chan;
        logic ena;
        logic sop;
        logic eop;
        logic err;
        logic [`TSBI_MTY_W-1:0] mty;
        logic bctl;
    } seg_t;

    typedef seg_t [`TSBI_NSEG-1:0] beat_t;

endpackage : tsbi_pkg

// *** rtl/tsbi_if.sv ***
// Segmented local bus between the packet source and the ingress device.
// Assumes both ends run on one clock, which is not carried here.
`timescale 1ns/1ps
`include "tsbi_map.svh"

interface tsbi_if;
    tsbi_pkg::beat_t tx_seg;
    logic tx_rdy;
    logic tx_ovf;

    modport device (
        input tx_seg,
        output tx_rdy,
        output tx_ovf
    );

    modport source (
        output tx_seg,
        input tx_rdy,
        input tx_ovf
    );
endinterface : tsbi_if

// *** rtl/tsbi_device.sv ***
// Ingress end: samples the segmented bus, buffers beats, marks burst control.
// Assumes one clock core_clk and a source that honours tx_rdy.
//
// Contract
// - Error flagged on final transfer marks packet errored
// - Error counts only with valid and end
// - Source gives empty byte count on last transfer
// - Empty count sampled only with valid and end
// - Errored end zeroes low three empty bits
// - Forced burst control word precedes segment data
// - Forcing scheduler uses enhanced scheduling algorithm; here force is the user bctl flag, no scheduler
// - Segment carries data, channel, strobes, flags, counts
// - Segment captured only when its strobe high
// - Start flag marks first transfer only
// - Ready from fill threshold; source stops when low
// - Overflow shown when source ignores ready
`timescale 1ns/1ps
`include "tsbi_map.svh"

module tsbi_device (
    input wire logic core_clk,
    input wire logic rst_n,
    tsbi_if.device bus,
    output logic out_valid,
    input wire logic out_ready,
    output tsbi_pkg::beat_t out_beat,
    output logic [`TSBI_STAT_W-1:0] pkt_count,
    output logic [`TSBI_STAT_W-1:0] err_pkt_count
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Empty count as applied, low bits dropped on error
    function automatic logic [`TSBI_MTY_W-1:0] tsbi_mty(
        input logic err,
        input logic [`TSBI_MTY_W-1:0] mty
    );
        if (err) begin
            tsbi_mty = {mty[`TSBI_MTY_W-1], `TSBI_MTY_LOW_ZERO};
        end else begin
            tsbi_mty = mty;
        end
    endfunction : tsbi_mty

    // Whether a segment opens with a burst control word
    function automatic logic tsbi_bctl_due(
        input logic force_bctl,
        input logic start,
        input logic [`TSBI_BURST_CNT_W-1:0] cnt
    );
        tsbi_bctl_due = force_bctl || start || (cnt >= `TSBI_MAX_BURST_SEGS);
    endfunction : tsbi_bctl_due

    // Packet ends in a beat, all or errored only
    function automatic logic [2:0] tsbi_count_ends(
        input tsbi_pkg::beat_t beat,
        input logic only_err
    );
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < `TSBI_NSEG; i++) begin
            if (beat[i].ena && beat[i].eop && (beat[i].err || !only_err)) begin
                n = n + 3'h1;
            end
        end
        tsbi_count_ends = n;
    endfunction : tsbi_count_ends

    // ----------------------------------------
    // Beat capture and burst control marking
    // ----------------------------------------
    tsbi_pkg::beat_t beat_d;
    logic [`TSBI_BURST_CNT_W-1:0] burst_cnt_q;
    logic [`TSBI_BURST_CNT_W-1:0] burst_cnt_d;
    logic any_ena;
    logic wr_en;
    logic rd_en;

    always_comb begin
        burst_cnt_d = burst_cnt_q;
        any_ena = 1'b0;
        // Segments walked from zero upward, earliest first
        for (int i = 0; i < `TSBI_NSEG; i++) begin
            beat_d[i] = '0;
            if (bus.tx_seg[i].ena) begin
                any_ena = 1'b1;
                beat_d[i].data = bus.tx_seg[i].data;
                beat_d[i].chan = bus.tx_seg[i].chan;
                beat_d[i].ena = 1'b1;
                beat_d[i].sop = bus.tx_seg[i].sop;
                beat_d[i].eop = bus.tx_seg[i].eop;
                if (bus.tx_seg[i].eop) begin
                    beat_d[i].err = bus.tx_seg[i].err;
                    beat_d[i].mty = tsbi_mty(bus.tx_seg[i].err, bus.tx_seg[i].mty);
                end
                // Control word on force, packet start, or burst limit reached
                beat_d[i].bctl = tsbi_bctl_due(bus.tx_seg[i].bctl, bus.tx_seg[i].sop, burst_cnt_d);
                if (beat_d[i].bctl) begin
                    burst_cnt_d = `TSBI_BURST_CNT_W'(1);
                end else begin
                    burst_cnt_d = burst_cnt_d + `TSBI_BURST_CNT_W'(1);
                end
            end
        end
    end

    // ----------------------------------------
    // Burst counter
    // ----------------------------------------
    // Counter only moves when the beat is taken
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            burst_cnt_q <= '0;
        end else if (wr_en) begin
            burst_cnt_q <= burst_cnt_d;
        end
    end

    // ----------------------------------------
    // Two-entry buffer
    // ----------------------------------------
    tsbi_pkg::beat_t buf_mem [`TSBI_BUF_DEPTH];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [`TSBI_CNT_W-1:0] fill_q;

    // Full buffer refuses; a strobe then is lost and flagged
    assign bus.tx_rdy = (fill_q < `TSBI_FILL_THRESH);
    assign wr_en = any_ena && bus.tx_rdy;
    assign out_valid = (fill_q != `TSBI_CNT_W'(0));
    assign rd_en = out_valid && out_ready;
    assign out_beat = buf_mem[rd_ptr_q];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else if (wr_en) begin
            buf_mem[wr_ptr_q] <= beat_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (wr_en) begin
                wr_ptr_q <= !wr_ptr_q;
            end
            if (rd_en) begin
                rd_ptr_q <= !rd_ptr_q;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fill_q <= '0;
        end else if (wr_en && !rd_en) begin
            fill_q <= fill_q + `TSBI_CNT_W'(1);
        end else if (rd_en && !wr_en) begin
            fill_q <= fill_q - `TSBI_CNT_W'(1);
        end
    end

    // ----------------------------------------
    // Overflow indication
    // ----------------------------------------
    logic ovf_q;
    // One pulse for each offending cycle

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= any_ena && !bus.tx_rdy;
        end
    end

    assign bus.tx_ovf = ovf_q;

    // ----------------------------------------
    // Packet statistics
    // ----------------------------------------
    logic [`TSBI_STAT_W-1:0] pkt_count_q;
    logic [`TSBI_STAT_W-1:0] err_pkt_count_q;
    // Counters wrap; they count accepted packet ends

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pkt_count_q <= '0;
        end else if (wr_en) begin
            pkt_count_q <= pkt_count_q + `TSBI_STAT_W'(tsbi_count_ends(beat_d, 1'b0));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            err_pkt_count_q <= '0;
        end else if (wr_en) begin
            err_pkt_count_q <= err_pkt_count_q + `TSBI_STAT_W'(tsbi_count_ends(beat_d, 1'b1));
        end
    end

    assign pkt_count = pkt_count_q;
    assign err_pkt_count = err_pkt_count_q;

endmodule : tsbi_device

// *** rtl/tsbi_source.sv ***
// Source end: holds one user beat and presents it on the segmented bus.
// Assumes the user packs segments from zero upward and one clock core_clk.
`timescale 1ns/1ps
`include "tsbi_map.svh"

module tsbi_source (
    input wire logic core_clk,
    input wire logic rst_n,
    tsbi_if.source bus,
    input wire logic usr_valid,
    output logic usr_ready,
    input tsbi_pkg::beat_t usr_beat,
    output logic ovf_seen
);

    // ----------------------------------------
    // Holding register
    // ----------------------------------------
    tsbi_pkg::beat_t hold_q;
    tsbi_pkg::beat_t clean_d;
    logic hold_valid_q;
    logic load;

    assign usr_ready = !hold_valid_q || bus.tx_rdy;
    assign load = usr_valid && usr_ready;

    always_comb begin
        for (int i = 0; i < `TSBI_NSEG; i++) begin
            clean_d[i] = usr_beat[i];
            clean_d[i].sop = usr_beat[i].ena && usr_beat[i].sop;
            clean_d[i].err = usr_beat[i].ena && usr_beat[i].eop && usr_beat[i].err;
            if (!(usr_beat[i].ena && usr_beat[i].eop)) begin
                clean_d[i].mty = '0;
            end
            // Forced control words come from the user bctl flag, gated by strobe
            clean_d[i].bctl = usr_beat[i].ena && usr_beat[i].bctl;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hold_q <= '0;
        end else if (load) begin
            hold_q <= clean_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hold_valid_q <= 1'b0;
        end else if (load) begin
            hold_valid_q <= 1'b1;
        end else if (bus.tx_rdy) begin
            hold_valid_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Bus drive, strobes gated by ready
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < `TSBI_NSEG; i++) begin
            // Idle segments driven to zero so no stale sideband shows
            bus.tx_seg[i] = '0;
            if (hold_q[i].ena && hold_valid_q && bus.tx_rdy) begin
                bus.tx_seg[i] = hold_q[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ovf_seen <= 1'b0;
        end else if (bus.tx_ovf) begin
            ovf_seen <= 1'b1;
        end
    end

endmodule : tsbi_source

// *** test/tsbi_chk.sv ***
// Checker of the segmented bus between source and device.
// Assumes instantiation beside the interface, one clock.
`timescale 1ns/1ps
`include "tsbi_map.svh"
module tsbi_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input tsbi_pkg::beat_t tx_seg,
    input wire logic tx_rdy,
    input wire logic tx_ovf
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic any_ena;
    assign any_ena = tx_seg[0].ena | tx_seg[1].ena | tx_seg[2].ena | tx_seg[3].ena;
    a_ovf_on_push: assert property (any_ena && !tx_rdy |=> tx_ovf)
        else $error("no overflow pulse");
    a_ovf_no_cause: assert property (!(any_ena && !tx_rdy) |=> !tx_ovf)
        else $error("stray overflow");
    a_stop_when_busy: assert property (!tx_rdy |-> !any_ena)
        else $error("strobe while not ready");
    a_ready_returns: assert property ($fell(tx_rdy) |-> ##[1:40] tx_rdy)
        else $error("ready stuck low");
    for (genvar i = 0; i < `TSBI_NSEG; i++) begin : g_seg
        a_err_with_end: assert property (tx_seg[i].err |-> tx_seg[i].ena && tx_seg[i].eop)
            else $error("error flag off end");
        a_mty_with_end: assert property (tx_seg[i].mty != 4'h0 |-> tx_seg[i].ena && tx_seg[i].eop)
            else $error("empty count off end");
        a_sop_with_ena: assert property (tx_seg[i].sop |-> tx_seg[i].ena)
            else $error("start without strobe");
        a_bctl_with_ena: assert property (tx_seg[i].bctl |-> tx_seg[i].ena)
            else $error("force without strobe");
    end
    cover property ($fell(tx_rdy));
    cover property (tx_seg[0].err);
    cover property (tx_seg[3].bctl);
endmodule : tsbi_chk

// *** test/tx_segmented_bus_ingress_test.sv ***
// Bench joining source and device ends over the segmented bus.
// Assumes the design files compile first.
`timescale 1ns/1ps
module tx_segmented_bus_ingress_test;
    logic core_clk, rst_n, usr_valid, usr_ready, out_valid, out_ready, ovf_seen;
    tsbi_pkg::beat_t usr_beat, out_beat, q[$];
    logic [15:0] pkt_count, err_pkt_count;
    int fail_count = 0, compares = 0, cyc = 0, bcnt = 0, npkt = 0, nerr = 0;
    tsbi_if bus_if ();
    tsbi_if bad_if ();
    tsbi_source tsbi_source_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if), .usr_valid(usr_valid),
        .usr_ready(usr_ready), .usr_beat(usr_beat), .ovf_seen(ovf_seen));
    tsbi_device tsbi_device_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(bus_if), .out_valid(out_valid),
        .out_ready(out_ready), .out_beat(out_beat), .pkt_count(pkt_count), .err_pkt_count(err_pkt_count));
    tsbi_device tsbi_device_inst2 (.core_clk(core_clk), .rst_n(rst_n), .bus(bad_if), .out_valid(),
        .out_ready(1'b0), .out_beat(), .pkt_count(), .err_pkt_count());
    tsbi_chk tsbi_chk_inst (.core_clk(core_clk), .rst_n(rst_n), .tx_seg(bus_if.tx_seg),
        .tx_rdy(bus_if.tx_rdy), .tx_ovf(bus_if.tx_ovf));
    task automatic chk_beat(input tsbi_pkg::beat_t got, input tsbi_pkg::beat_t exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_beat
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // Flags f are ena, sop, eop, err, bctl
    function automatic tsbi_pkg::seg_t sg(input logic [7:0] d, input logic [4:0] f, input logic [3:0] m);
        return '{data: {16{d}}, chan: {3'h0, d}, ena: f[4], sop: f[3], eop: f[2], err: f[1], mty: m, bctl: f[0]};
    endfunction : sg
    function automatic tsbi_pkg::beat_t model(input tsbi_pkg::beat_t b);
        tsbi_pkg::beat_t r;
        logic m;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            if (b[i].ena) begin
                r[i] = b[i];
                r[i].err = b[i].err & b[i].eop;
                r[i].mty = !b[i].eop ? 4'h0 : r[i].err ? {b[i].mty[3], 3'h0} : b[i].mty;
                m = b[i].bctl | b[i].sop | (bcnt == 16);
                r[i].bctl = m;
                bcnt = m ? 1 : bcnt + 1;
                npkt += b[i].eop;
                nerr += r[i].err;
            end
        end
        return r;
    endfunction : model
    task automatic send(input tsbi_pkg::beat_t b);
        usr_beat = b;
        usr_valid = 1'b1;
        q.push_back(model(b));
        while (usr_ready !== 1'b1) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        #1;
    endtask : send
    task automatic drain();
        usr_valid = 1'b0;
        for (int i = 0; i < 60 && q.size() != 0; i++) @(posedge core_clk);
        #1;
        chk_val(16'(q.size()), 16'h0);
    endtask : drain
    always @(negedge core_clk) begin
        cyc <= cyc + 1;
        if (rst_n && out_valid === 1'b1 && out_ready === 1'b1)
            chk_beat(out_beat, q.pop_front());
        if (cyc == 3000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        rst_n = 1'b0;
        usr_valid = 1'b0;
        usr_beat = '0;
        out_ready = 1'b1;
        bad_if.tx_seg = '0;
        repeat (4) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        send({sg(8'h13,5'h11,4'h0), sg(8'h12,5'h0f,4'h7), sg(8'h11,5'h10,4'h0), sg(8'h10,5'h18,4'h0)});
        send({sg(8'h23,5'h18,4'h0), sg(8'h22,5'h0f,4'h7), sg(8'h21,5'h1c,4'h5), sg(8'h20,5'h16,4'hf)});
        send({sg(8'h33,5'h00,4'h0), sg(8'h32,5'h00,4'h0), sg(8'h31,5'h16,4'h3), sg(8'h30,5'h12,4'h6)});
        drain();
        $display("Test sideband done");
        out_ready = 1'b0;
        fork
            begin
                repeat (8) @(posedge core_clk);
                #1;
                chk_val({15'h0, bus_if.tx_rdy}, 16'h0);
                out_ready = 1'b1;
            end
        join_none
        for (int k = 0; k < 5; k++)
            send({sg(8'h43, k == 4 ? 5'h14 : 5'h10, k == 4 ? 4'h1 : 4'h0), sg(8'h42, 5'h10, 4'h0),
                sg(8'h41, 5'h10, 4'h0), sg(8'h40, k == 0 ? 5'h18 : 5'h10, 4'h0)});
        drain();
        chk_val(pkt_count, 16'(npkt));
        chk_val(err_pkt_count, 16'(nerr));
        chk_val({15'h0, ovf_seen}, 16'h0);
        $display("Test burst and stall done");
        bad_if.tx_seg = {sg(8'h0, 5'h00, 4'h0), sg(8'h0, 5'h00, 4'h0), sg(8'h0, 5'h00, 4'h0), sg(8'h50, 5'h1c, 4'h0)};
        repeat (3) @(posedge core_clk);
        #1;
        bad_if.tx_seg = '0;
        chk_val({15'h0, bad_if.tx_ovf}, 16'h1);
        @(posedge core_clk);
        #1;
        chk_val({15'h0, bad_if.tx_ovf}, 16'h0);
        $display("Test overflow done");
        finish_test();
    end
endmodule : tx_segmented_bus_ingress_test
